// *** core/dmx_defines.svh ***
`ifndef DMX_DEFINES_SVH
`define DMX_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DMX_OFS_CTRL 8'h00
`define DMX_OFS_INSTR 8'h04
`define DMX_OFS_WREG 8'h08
`define DMX_OFS_BANK 8'h0C
`define DMX_OFS_STATUS 8'h10
`define DMX_OFS_FSR2 8'h14
`define DMX_OFS_MADDR 8'h18
`define DMX_OFS_MDATA 8'h1C

// ****************************************
// Field positions
// ****************************************
`define DMX_CTRL_EXT_BIT 0
`define DMX_STAT_Z_BIT 0
`define DMX_STAT_N_BIT 1
`define DMX_STAT_BUSY_BIT 8
`define DMX_STAT_WAIT_BIT 9
`define DMX_IR_D_BIT 9
`define DMX_IR_A_BIT 8

// ****************************************
// Encodings and addresses
// ****************************************
`define DMX_OP_MOVE_FD 6'h14
`define DMX_OP_FF_SRC 4'hC
`define DMX_OP_FF_DST 4'hF
`define DMX_OP_LIT_BANK 8'h01
`define DMX_OP_LIT_ACC 8'h0E
`define DMX_OP_ACC_FILE 7'h37
`define DMX_INDEXED_MAX 8'h5F
`define DMX_ACCESS_SPLIT 8'h60
`define DMX_ACCESS_HI 4'hF
`define DMX_ACCESS_LO 4'h0
`define DMX_ACC_ADDR 12'hFE8

// ****************************************
// Reset values
// ****************************************
`define DMX_RST_BYTE 8'h00
`define DMX_RST_ADDR 12'h000
`define DMX_RST_IR 16'h0000

`endif

// *** core/dmx_pkg.sv ***
package dmx_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_Q1,
		ST_Q2,
		ST_Q3,
		ST_Q4
	} dmx_phase_t;

	typedef logic [11:0] dmx_addr_t;
	typedef logic [7:0] dmx_byte_t;
	typedef logic [15:0] dmx_word_t;

endpackage

// *** core/dmx_data_mem.sv ***
`include "dmx_defines.svh"

module dmx_data_mem (
	// Clock
	input wire logic clk,
	// Single port
	input wire logic we,
	input wire dmx_pkg::dmx_addr_t addr,
	input wire dmx_pkg::dmx_byte_t wdata,
	output dmx_pkg::dmx_byte_t rdata
);

	dmx_pkg::dmx_byte_t mem [0:4095];

	// Read data registered; a same-cycle write returns the old byte
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule

// *** core/dmx_core.sv ***
// Summary of operation
// [RULE_01] File move writes accumulator when d is 0, the file when d is 1.
// [RULE_02] Single-word file operand reaches any byte of the selected 256-byte bank.
// [RULE_03] Access bit 0 uses access bank; 1 uses bank select register bank.
// [RULE_04] Access bit 0, extended set on, operand up to 95: indexed offset mode.
// [RULE_05] File move is one word, one cycle: decode, read, process, write.
// [RULE_06] File-to-file move takes 12-bit source and destination, copies source value.
// [RULE_07] File-to-file words: 1100 plus source, then 1111 plus destination.
// [RULE_08] File-to-file takes two cycles; second has no dummy read, writes in last phase.
// [RULE_09] File-to-file allows accumulator as source or destination; flags untouched.
// [RULE_10] Software must not target program counter low or stack top bytes.
// [RULE_11] Literal-to-bank loads bank select with upper four bits forced 0.
// [RULE_12] Literal-to-accumulator 0000 1110 loads literal, flags untouched, one cycle.
// [RULE_13] Accumulator-to-file 0110 111a stores accumulator in file, flags untouched.
// [RULE_14] File move updates negative and zero flags from the moved value only.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`include "dmx_defines.svh"

module dmx_core (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// AXI4-Lite write address
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	// ****************************************
	// State
	// ****************************************
	dmx_pkg::dmx_phase_t phase;
	dmx_pkg::dmx_word_t ir;
	dmx_pkg::dmx_byte_t acc;
	dmx_pkg::dmx_byte_t bank_select_register;
	dmx_pkg::dmx_byte_t op_val;
	dmx_pkg::dmx_addr_t op_addr;
	dmx_pkg::dmx_addr_t fsr2;
	dmx_pkg::dmx_addr_t dbg_addr;
	logic ext_en;
	logic flag_n;
	logic flag_z;
	logic await_dest;
	logic in_second;
	logic mem_stale;
	dmx_pkg::dmx_byte_t mem_rdata;

	// ****************************************
	// Bus decode
	// ****************************************
	logic [31:0] wmask;
	logic [31:0] wval;
	logic wr_take;
	logic wr_fire;
	logic rd_take;
	logic rd_fire;
	logic busy;
	logic wr_ctrl;
	logic wr_instr;
	logic wr_acc;
	logic wr_fsr2;
	logic wr_maddr;
	logic wr_mdata;
	logic wr_bank;
	logic wr_stat;
	logic wr_known;
	logic wr_reject;
	logic rd_known;
	logic rd_reject;
	logic [31:0] rd_word;

	assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
		{8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
	assign wval = S_AXI_WDATA & wmask;
	assign wr_take = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
	assign wr_fire = S_AXI_AWREADY && S_AXI_WREADY;
	assign rd_take = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
	assign rd_fire = S_AXI_ARREADY && S_AXI_ARVALID;
	assign busy = (phase != dmx_pkg::ST_IDLE);

	assign wr_ctrl = (S_AXI_AWADDR == `DMX_OFS_CTRL);
	assign wr_instr = (S_AXI_AWADDR == `DMX_OFS_INSTR);
	assign wr_acc = (S_AXI_AWADDR == `DMX_OFS_WREG);
	assign wr_bank = (S_AXI_AWADDR == `DMX_OFS_BANK);
	assign wr_stat = (S_AXI_AWADDR == `DMX_OFS_STATUS);
	assign wr_fsr2 = (S_AXI_AWADDR == `DMX_OFS_FSR2);
	assign wr_maddr = (S_AXI_AWADDR == `DMX_OFS_MADDR);
	assign wr_mdata = (S_AXI_AWADDR == `DMX_OFS_MDATA);
	assign wr_known = wr_ctrl || wr_instr || wr_acc || wr_bank || wr_stat ||
		wr_fsr2 || wr_maddr || wr_mdata;
	// Anything touching core state while an instruction runs is refused
	assign wr_reject = !wr_known || (busy && !wr_bank && !wr_stat);

	assign rd_known = (S_AXI_ARADDR[7:5] == 3'h0) && (S_AXI_ARADDR[1:0] == 2'h0);
	// Memory port is the core's while busy and its read lags a cycle: refuse both
	assign rd_reject = !rd_known || ((busy || mem_stale) && (S_AXI_ARADDR == `DMX_OFS_MDATA));

	always_comb begin
		rd_word = 32'h00000000;
		unique case (S_AXI_ARADDR)
			`DMX_OFS_CTRL: rd_word[`DMX_CTRL_EXT_BIT] = ext_en;
			`DMX_OFS_INSTR: rd_word[15:0] = ir;
			`DMX_OFS_WREG: rd_word[7:0] = acc;
			`DMX_OFS_BANK: rd_word[7:0] = bank_select_register;
			`DMX_OFS_STATUS: begin
				rd_word[`DMX_STAT_Z_BIT] = flag_z;
				rd_word[`DMX_STAT_N_BIT] = flag_n;
				rd_word[`DMX_STAT_BUSY_BIT] = busy;
				rd_word[`DMX_STAT_WAIT_BIT] = await_dest;
			end
			`DMX_OFS_FSR2: rd_word[11:0] = fsr2;
			`DMX_OFS_MADDR: rd_word[11:0] = dbg_addr;
			`DMX_OFS_MDATA: rd_word[7:0] = mem_rdata;
			default: rd_word = 32'h00000000;
		endcase
	end

	// ****************************************
	// Instruction decode
	// ****************************************
	logic start;
	logic is_move_fd;
	logic is_ff_src;
	logic is_ff_dst;
	logic is_lit_bank;
	logic is_lit_acc;
	logic is_acc_file;
	logic bit_d;
	logic bit_a;
	dmx_pkg::dmx_byte_t fop;
	dmx_pkg::dmx_addr_t indexed_addr;
	dmx_pkg::dmx_addr_t access_addr;
	dmx_pkg::dmx_addr_t bank_addr;
	dmx_pkg::dmx_addr_t eff_addr;
	logic op_is_acc;
	dmx_pkg::dmx_byte_t file_val;

	assign start = wr_fire && wr_instr && !wr_reject;
	assign fop = ir[7:0];
	assign bit_d = ir[`DMX_IR_D_BIT];
	assign bit_a = ir[`DMX_IR_A_BIT];
	assign is_move_fd = (ir[15:10] == `DMX_OP_MOVE_FD);
	assign is_ff_src = (ir[15:12] == `DMX_OP_FF_SRC); // [RULE_07]
	assign is_ff_dst = in_second; // [RULE_07]
	assign is_lit_bank = (ir[15:8] == `DMX_OP_LIT_BANK);
	assign is_lit_acc = (ir[15:8] == `DMX_OP_LIT_ACC); // [RULE_12]
	assign is_acc_file = (ir[15:9] == `DMX_OP_ACC_FILE); // [RULE_13]

	// Indexed offset adds the literal to the pointer; wraps in 4 KB space
	assign indexed_addr = fsr2 + {4'h0, fop}; // [RULE_04]
	assign access_addr = (fop < `DMX_ACCESS_SPLIT) ? {`DMX_ACCESS_LO, fop} :
		{`DMX_ACCESS_HI, fop}; // [RULE_03]
	always_comb begin
		if (bit_a) begin
			bank_addr = {bank_select_register[3:0], fop}; // [RULE_02] [RULE_03]
		end else if (ext_en && (fop <= `DMX_INDEXED_MAX)) begin
			bank_addr = indexed_addr; // [RULE_04]
		end else begin
			bank_addr = access_addr; // [RULE_03]
		end
	end
	// Long move carries its full 12-bit addresses in the words themselves
	assign eff_addr = (is_ff_src || is_ff_dst) ? ir[11:0] : bank_addr; // [RULE_06]

	// Accumulator is also visible at its file address
	assign op_is_acc = (op_addr == `DMX_ACC_ADDR); // [RULE_09]
	assign file_val = op_is_acc ? acc : mem_rdata; // [RULE_09]

	// ****************************************
	// Write-phase effects
	// ****************************************
	logic q4;
	logic file_wr;
	dmx_pkg::dmx_byte_t file_wdata;
	logic acc_wr;
	dmx_pkg::dmx_byte_t next_acc;
	logic mem_we;
	dmx_pkg::dmx_addr_t mem_addr;
	dmx_pkg::dmx_byte_t mem_wdata;
	logic dbg_we;

	assign q4 = (phase == dmx_pkg::ST_Q4);
	assign file_wr = q4 && ((is_move_fd && bit_d) || is_ff_dst || is_acc_file); // [RULE_01]
	assign file_wdata = is_acc_file ? acc : op_val; // [RULE_13] [RULE_06]
	assign acc_wr = (file_wr && op_is_acc) || (q4 && is_move_fd && !bit_d) ||
		(q4 && is_lit_acc); // [RULE_01] [RULE_09]
	always_comb begin
		if (!busy) begin
			next_acc = wval[7:0];
		end else if (is_lit_acc) begin
			next_acc = fop; // [RULE_12]
		end else if (is_move_fd) begin
			next_acc = op_val; // [RULE_01]
		end else begin
			next_acc = file_wdata;
		end
	end

	assign dbg_we = wr_fire && wr_mdata && !wr_reject;
	assign mem_we = (file_wr && !op_is_acc) || dbg_we;
	assign mem_addr = busy ? op_addr : dbg_addr;
	assign mem_wdata = busy ? file_wdata : wval[7:0];

	dmx_data_mem u_mem (
		.clk(CLK_SYS),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// ****************************************
	// Phase sequencer
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			phase <= dmx_pkg::ST_IDLE;
		end else begin
			unique case (phase)
				dmx_pkg::ST_IDLE: if (start) begin
					phase <= dmx_pkg::ST_Q1;
				end
				dmx_pkg::ST_Q1: phase <= dmx_pkg::ST_Q2; // [RULE_05]
				dmx_pkg::ST_Q2: phase <= dmx_pkg::ST_Q3;
				dmx_pkg::ST_Q3: phase <= dmx_pkg::ST_Q4;
				dmx_pkg::ST_Q4: phase <= dmx_pkg::ST_IDLE; // [RULE_05]
			endcase
		end
	end

	// A destination word pairs only with a pending source word
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ir <= `DMX_RST_IR;
			in_second <= 1'b0;
			await_dest <= 1'b0;
		end else if (start) begin
			ir <= wval[15:0];
			in_second <= await_dest && (wval[15:12] == `DMX_OP_FF_DST); // [RULE_08]
			await_dest <= 1'b0;
		end else if (q4) begin
			await_dest <= is_ff_src && !in_second; // [RULE_08]
		end
	end

	// Operand address in Q1, operand captured in Q3
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			op_addr <= `DMX_RST_ADDR;
			op_val <= `DMX_RST_BYTE;
			mem_stale <= 1'b0;
		end else begin
			mem_stale <= q4;
			if (phase == dmx_pkg::ST_Q1) begin
				op_addr <= eff_addr;
			end
			// Second long-move cycle keeps the source byte: no dummy read
			if ((phase == dmx_pkg::ST_Q3) && !is_ff_dst) begin
				op_val <= file_val; // [RULE_08] [RULE_06]
			end
		end
	end

	// ****************************************
	// Core registers
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			acc <= `DMX_RST_BYTE;
		end else if (acc_wr || (wr_fire && wr_acc && !wr_reject)) begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			bank_select_register <= `DMX_RST_BYTE;
		end else if (q4 && is_lit_bank) begin
			bank_select_register <= {4'h0, ir[3:0]}; // [RULE_11]
		end
	end

	// Only the plain file move touches the flags
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			flag_n <= 1'b0;
			flag_z <= 1'b0;
		end else if (q4 && is_move_fd) begin
			flag_n <= op_val[7]; // [RULE_14]
			flag_z <= (op_val == 8'h00); // [RULE_14]
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ext_en <= 1'b0;
			fsr2 <= `DMX_RST_ADDR;
			dbg_addr <= `DMX_RST_ADDR;
		end else if (wr_fire && !wr_reject) begin
			if (wr_ctrl) begin
				ext_en <= wval[`DMX_CTRL_EXT_BIT];
			end
			if (wr_fsr2) begin
				fsr2 <= wval[11:0];
			end
			if (wr_maddr) begin
				dbg_addr <= wval[11:0];
			end
		end
	end

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
		end else begin
			S_AXI_AWREADY <= wr_take;
			S_AXI_WREADY <= wr_take;
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_reject ? 2'h2 : 2'h0;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= 2'h0;
		end else begin
			S_AXI_ARREADY <= rd_take;
			if (rd_fire) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_reject ? 32'h00000000 : rd_word;
				S_AXI_RRESP <= rd_reject ? 2'h2 : 2'h0;
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule

// *** verification/dmx_core_chk.sv ***
module dmx_core_chk (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// Write side
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// Read side
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	// ****
	// Handshake steps
	// ****
	sequence s_wr_req;
		S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
	endsequence
	sequence s_wr_ans;
		S_AXI_AWREADY && S_AXI_WREADY ##1 S_AXI_BVALID;
	endsequence
	sequence s_rd_req;
		S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
	endsequence
	sequence s_rd_ans;
		S_AXI_ARREADY ##1 S_AXI_RVALID;
	endsequence
	wr_answer_a: assert property (s_wr_req |=> s_wr_ans)
		else $error("write not answered on time");
	rd_answer_a: assert property (s_rd_req |=> s_rd_ans)
		else $error("read not answered on time");
	ready_pair_a: assert property (S_AXI_AWREADY |-> S_AXI_WREADY ##1 !S_AXI_AWREADY)
		else $error("write ready not a paired pulse");
	bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	bvalid_drop_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response not retired");
	rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
	rvalid_drop_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read data not retired");
	bresp_code_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0 || S_AXI_BRESP == 2'h2)
		else $error("bad write response code");
	rerr_zero_a: assert property (S_AXI_RVALID && S_AXI_RRESP != 2'h0 |-> S_AXI_RDATA == 32'h0)
		else $error("refused read carries data");
endmodule

bind dmx_core dmx_core_chk u_dmx_core_chk (
	.CLK_SYS(CLK_SYS),
	.RSTN(RSTN),
	.S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY)
);

// *** verification/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	wire [3:0] hs = {bvalid, awready, rvalid, arready};
	int err_count = 0;
	int n_checks = 0;
	always #12.5 clk = ~clk;
	dmx_core u_dmx_core (
		.CLK_SYS(clk),
		.RSTN(rstn),
		.S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready)
	);
	// ****
	// Bus tasks
	// ****
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Samples the value held at the edge, before that edge's updates land
	task automatic wt(input int s);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hs[s] !== 1'b1 && i < 60);
		if (i >= 60) begin
			chk("handshake", 32'h0, 32'h1);
			print_verdict();
		end
	endtask
	// Ready for the answer is raised late so the hold of the response is exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		wt(2);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wt(3);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, e});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
		araddr <= a;
		arvalid <= 1'b1;
		wt(0);
		arvalid <= 1'b0;
		wt(1);
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
		chk("rdata", rdata, x);
		chk("rresp", {30'h0, rresp}, {30'h0, e});
	endtask
	// Execution takes four cycles after the write edge
	task automatic exec(input logic [15:0] w);
		wr(8'h04, {16'h0, w}, 2'h0);
		repeat (5) @(posedge clk);
	endtask
	task automatic poke(input logic [11:0] a, input logic [7:0] d);
		wr(8'h18, {20'h0, a}, 2'h0);
		wr(8'h1C, {24'h0, d}, 2'h0);
	endtask
	task automatic peek(input logic [11:0] a, input logic [7:0] x);
		wr(8'h18, {20'h0, a}, 2'h0);
		rd(8'h1C, {24'h0, x}, 2'h0);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_bus();
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h10, 32'h0, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h20, 32'h5, 2'h2);
		wr(8'h0C, 32'h5, 2'h0);
		rd(8'h0C, 32'h0, 2'h0);
		$display("t_bus done");
	endtask
	// The second write lands in the final phase, so it must be refused as busy
	task automatic t_lit();
		wr(8'h04, 32'h0E80, 2'h0);
		wr(8'h08, 32'h55, 2'h2);
		rd(8'h08, 32'h80, 2'h0);
		rd(8'h10, 32'h0, 2'h0);
		exec(16'h01F7);
		rd(8'h0C, 32'h7, 2'h0);
		$display("t_lit done");
	endtask
	task automatic t_file_to_dest_move();
		exec(16'h0103);
		poke(12'h345, 8'h80);
		exec(16'h5145);
		rd(8'h08, 32'h80, 2'h0);
		rd(8'h10, 32'h2, 2'h0);
		poke(12'h3FF, 8'h00);
		exec(16'h53FF);
		rd(8'h10, 32'h1, 2'h0);
		rd(8'h08, 32'h80, 2'h0);
		peek(12'h3FF, 8'h00);
		poke(12'h010, 8'h11);
		exec(16'h5010);
		rd(8'h08, 32'h11, 2'h0);
		poke(12'hF80, 8'h44);
		exec(16'h5080);
		rd(8'h08, 32'h44, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		wr(8'h14, 32'h200, 2'h0);
		poke(12'h25F, 8'h66);
		exec(16'h505F);
		rd(8'h08, 32'h66, 2'h0);
		poke(12'hF60, 8'h77);
		exec(16'h5060);
		rd(8'h08, 32'h77, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
		$display("t_file_to_dest_move done");
	endtask
	task automatic t_accumulator_to_file();
		wr(8'h08, 32'h5A, 2'h0);
		exec(16'h6F20);
		peek(12'h320, 8'h5A);
		exec(16'h6E05);
		peek(12'h005, 8'h5A);
		rd(8'h10, 32'h0, 2'h0);
		$display("t_accumulator_to_file done");
	endtask
	// Zero flag is set first so that an unwanted flag update would show
	task automatic t_file_to_file_move();
		exec(16'h53FF);
		poke(12'hFFF, 8'h99);
		exec(16'hCFFF);
		rd(8'h10, 32'h201, 2'h0);
		exec(16'hF000);
		peek(12'h000, 8'h99);
		rd(8'h10, 32'h1, 2'h0);
		poke(12'h123, 8'h77);
		exec(16'hC123);
		poke(12'h123, 8'h55);
		exec(16'hFFE8);
		rd(8'h08, 32'h77, 2'h0);
		wr(8'h08, 32'hA1, 2'h0);
		exec(16'hCFE8);
		exec(16'hF400);
		peek(12'h400, 8'hA1);
		poke(12'h001, 8'h12);
		exec(16'hCFFF);
		exec(16'h0E3C);
		rd(8'h10, 32'h1, 2'h0);
		exec(16'hF001);
		peek(12'h001, 8'h12);
		$display("t_file_to_file_move done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_bus();
		t_lit();
		t_file_to_dest_move();
		t_accumulator_to_file();
		t_file_to_file_move();
		print_verdict();
	end
endmodule
